// File: include/mbf_pkg.sv
package mbf_pkg;
  localparam int NUM_BUF = 16;
  localparam int ID_W    = 8;
  localparam int LEN_W   = 4;
  localparam int ADDR_W  = 8;
  // Byte offsets on the register bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_LOCK   = 8'h0C;
  localparam logic [7:0] OFS_FLAG   = 8'h10;
  localparam logic [7:0] OFS_ABORT  = 8'h14;
  localparam logic [7:0] OFS_WINSEL = 8'h18;
  localparam logic [7:0] OFS_WINHDR = 8'h1C;
  localparam logic [7:0] OFS_WINDAT = 8'h20;
  // Field positions
  localparam int CTRL_DEPTH_LSB = 0;
  localparam int CTRL_TXF_LSB   = 8;
  localparam int CTRL_IENE_BIT  = 16;
  localparam int CTRL_IEOVR_BIT = 17;
  localparam int ST_NE_BIT      = 0;
  localparam int ST_OVR_BIT     = 1;
  localparam int ST_IRQ_BIT     = 2;
  localparam int FLT_APAT_LSB   = 0;
  localparam int FLT_AMSK_LSB   = 8;
  localparam int FLT_RPAT_LSB   = 16;
  localparam int FLT_RMSK_LSB   = 24;
  localparam int HDR_LEN_LSB    = 8;
  // Values after reset, and bus response codes
  localparam logic [4:0]  RST_DEPTH  = 5'h00;
  localparam logic [3:0]  RST_TXF    = 4'hF;
  localparam logic [31:0] RST_FILTER = 32'hFF00_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench
  import mbf_pkg::*;
;
  typedef struct packed {
    logic [31:0]     filter;
    logic [ID_W-1:0] id;
    logic            ok;
    logic            hit;
    logic            stored;
  } mbf_row_t;
  logic              clk = 1'h0;
  logic              reset = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0000_0000;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'h0;
  logic              s_axi_wvalid = 1'h0;
  logic              s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0;
  logic              s_axi_rready = 1'h0;
  logic              rxDone = 1'h0;
  logic              rxOk = 1'h0;
  logic              rxMailboxHit = 1'h0;
  logic [ID_W-1:0]   rxId = 8'h00;
  logic [LEN_W-1:0]  rxLen = 4'h0;
  logic [31:0]       rxData = 32'h0000_0000;
  logic              syncPulse = 1'h0;
  logic              txDone = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, txValid, fifoIrq;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [1:0]        lastResp;
  logic [31:0]       s_axi_rdata, txData, rdVal;
  logic [3:0]        txBuf;
  logic [LEN_W-1:0]  txLen;
  logic [ID_W-1:0]   txId;
  logic [ID_W-1:0]   txIds [4] = '{8'h10, 8'h30, 8'h20, 8'h20};
  int                errCount = 0;
  int                nCompared = 0;
  int                cycles = 0;
  mbf_row_t          rows [10];

  always #12.5 clk = ~clk;

  mbf_msg_buffer u_mbf_msg_buffer (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rxDone(rxDone), .rxOk(rxOk), .rxMailboxHit(rxMailboxHit),
    .rxId(rxId), .rxLen(rxLen), .rxData(rxData),
    .syncPulse(syncPulse), .txDone(txDone), .txValid(txValid),
    .txBuf(txBuf), .txId(txId), .txLen(txLen), .txData(txData),
    .fifoIrq(fifoIrq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        lastResp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        rdVal = s_axi_rdata;
        lastResp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rx(input logic [7:0] id, input logic ok, input logic hit);
    @(posedge clk);
    rxDone <= 1'h1;
    rxId <= id;
    rxLen <= id[3:0];
    rxData <= {4{id}};
    rxOk <= ok;
    rxMailboxHit <= hit;
    @(posedge clk);
    rxDone <= 1'h0;
  endtask

  // Lock the FIFO, read the head message, release it
  task automatic pop(input logic [7:0] id);
    wr(OFS_LOCK, 32'h0000_0001);
    rd(OFS_LOCK);
    chk(rdVal, 32'h0001_0001);
    rd(OFS_WINHDR);
    chk(rdVal[11:0], {id[3:0], id});
    rd(OFS_WINDAT);
    chk(rdVal, {4{id}});
    wr(OFS_LOCK, 32'h0000_0000);
  endtask

  task automatic pulse_sync;
    @(posedge clk);
    syncPulse <= 1'h1;
    @(posedge clk);
    syncPulse <= 1'h0;
  endtask

  // Extra edges let the offer drop and recompute
  task automatic tx_done;
    @(posedge clk);
    txDone <= 1'h1;
    @(posedge clk);
    txDone <= 1'h0;
    repeat (2) @(posedge clk);
  endtask

  task automatic see_tx(input logic [3:0] b, input logic [7:0] id);
    int n;
    n = 0;
    while (txValid !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({txValid, txBuf, txId, txLen}, {1'h1, b, id, 4'h2});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      tally_and_finish;
    end
  end

  initial begin
    rows = '{
      '{32'hFF00_0000, 8'h01, 1'h1, 1'h0, 1'h0},
      '{32'h0055_0055, 8'h55, 1'h1, 1'h0, 1'h0},
      '{32'h0F00_FF00, 8'h05, 1'h1, 1'h0, 1'h0},
      '{32'h0F00_FF00, 8'h10, 1'h1, 1'h0, 1'h1},
      '{32'hCF30_7F00, 8'h80, 1'h1, 1'h0, 1'h0},
      '{32'hCF30_7F00, 8'h35, 1'h1, 1'h0, 1'h0},
      '{32'hCF30_7F00, 8'h45, 1'h1, 1'h0, 1'h1},
      '{32'hCF30_7F00, 8'h2F, 1'h1, 1'h0, 1'h1},
      '{32'h0F00_FF00, 8'h21, 1'h0, 1'h0, 1'h0},
      '{32'h0F00_FF00, 8'h22, 1'h1, 1'h1, 1'h0}};
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rd(OFS_CTRL);
    chk(rdVal, 32'h0000_0F00);
    rd(OFS_FILTER);
    chk(rdVal, RST_FILTER);
    rd(8'h40);
    chk(lastResp, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(lastResp, RESP_SLVERR);
    wr(OFS_CTRL, 32'h0000_0F04);
    foreach (rows[i]) begin
      wr(OFS_FILTER, rows[i].filter);
      rx(rows[i].id, rows[i].ok, rows[i].hit);
      rd(OFS_STATUS);
      chk(rdVal[0], rows[i].stored);
      if (rows[i].stored) pop(rows[i].id);
    end
    // Mid-run reset so the smaller FIFO starts from clean indices
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0000);
    wr(OFS_FILTER, 32'h0000_FF00);
    wr(OFS_CTRL, 32'h0001_0F03);
    for (int k = 1; k <= 3; k++) rx(8'(8'h10 + k), 1'h1, 1'h0);
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0005);
    chk(fifoIrq, 1'h1);
    rx(8'h14, 1'h0, 1'h0);
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0005);
    rx(8'h14, 1'h1, 1'h0);
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0007);
    for (int k = 1; k <= 3; k++) pop(8'(8'h10 + k));
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0002);
    chk(fifoIrq, 1'h0);
    wr(OFS_STATUS, 32'h0000_0002);
    rd(OFS_STATUS);
    chk(rdVal, 32'h0000_0000);
    rx(8'h16, 1'h1, 1'h0);
    pop(8'h16);
    // Transmit side: buffers 12 to 15
    wr(OFS_CTRL, 32'h0000_0C00);
    wr(OFS_LOCK, 32'h0000_F000);
    rd(OFS_LOCK);
    chk(rdVal, 32'hF000_F000);
    for (int b = 12; b < 16; b++) begin
      wr(OFS_WINSEL, 32'(b));
      wr(OFS_WINHDR, {20'h0_0000, 4'h2, txIds[b-12]});
      wr(OFS_WINDAT, {4{txIds[b-12]}});
    end
    wr(OFS_LOCK, 32'hF000_0000);
    wr(OFS_ABORT, 32'h0000_2000);
    rd(OFS_ABORT);
    chk(rdVal, 32'hF000_2000);
    chk(txValid, 1'h0);
    pulse_sync();
    see_tx(4'hC, 8'h10);
    tx_done();
    see_tx(4'hE, 8'h20);
    tx_done();
    repeat (4) @(posedge clk);
    chk(txValid, 1'h0);
    pulse_sync();
    rd(OFS_FLAG);
    chk(rdVal, 32'h2000_7000);
    wr(OFS_FLAG, 32'h2000_1000);
    rd(OFS_FLAG);
    chk(rdVal, 32'h0000_6000);
    see_tx(4'hF, 8'h20);
    chk(txData, {4{8'h20}});
    tally_and_finish;
  end
endmodule // testbench

// File: verilog/mbf_msg_buffer.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module mbf_msg_buffer
  import mbf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rxDone,
  input  wire logic              rxOk,
  input  wire logic              rxMailboxHit,
  input  wire logic [ID_W-1:0]   rxId,
  input  wire logic [LEN_W-1:0]  rxLen,
  input  wire logic [31:0]       rxData,
  input  wire logic              syncPulse,
  input  wire logic              txDone,
  output logic                   txValid,
  output logic [3:0]             txBuf,
  output logic [ID_W-1:0]        txId,
  output logic [LEN_W-1:0]       txLen,
  output logic [31:0]            txData,
  output logic                   fifoIrq
);
  typedef struct packed {
    logic                          awHave;
    logic                          wHave;
    logic [ADDR_W-1:0]             awAddr;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          rValid;
    logic [31:0]                   rData;
    logic [1:0]                    rResp;
    logic [4:0]                    depth;
    logic [3:0]                    txFirst;
    logic                          ieNe;
    logic                          ieOvr;
    logic                          ovr;
    logic [31:0]                   filt;
    logic [NUM_BUF-1:0]            lock;
    logic [NUM_BUF-1:0]            lockAck;
    logic [NUM_BUF-1:0]            flag;
    logic [NUM_BUF-1:0]            abAck;
    logic [NUM_BUF-1:0]            abReq;
    logic [NUM_BUF-1:0]            subm;
    logic [NUM_BUF-1:0]            armed;
    logic [NUM_BUF-1:0]            sent;
    logic [NUM_BUF-1:0]            excl;
    logic [3:0]                    winSel;
    logic [3:0]                    wrIdx;
    logic [3:0]                    rdIdx;
    logic                          full;
    logic [NUM_BUF-1:0][ID_W-1:0]  memId;
    logic [NUM_BUF-1:0][LEN_W-1:0] memLen;
    logic [NUM_BUF-1:0][31:0]      memData;
    logic                          txValid;
    logic [3:0]                    txBuf;
    logic [ID_W-1:0]               txId;
    logic [LEN_W-1:0]              txLen;
    logic [31:0]                   txData;
  } mbf_state_t;

  mbf_state_t st_r;
  mbf_state_t st_nxt;

  logic [31:0]        wMask;
  logic [NUM_BUF-1:0] txRange;
  logic [NUM_BUF-1:0] elig;
  logic               notEmpty;
  logic               acceptHit;
  logic               rejectHit;
  logic               wrFire;

  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : gen_range
      // Transmit region never overlaps the FIFO region
      assign txRange[g] = (4'(g) >= st_r.txFirst) &&
                          (5'(g) >= st_r.depth);
      assign elig[g] = st_r.armed[g] && !st_r.sent[g] &&
                       !st_r.excl[g] && !st_r.abReq[g];
    end
    for (g = 0; g < 4; g++) begin : gen_mask
      assign wMask[g*8 +: 8] = {8{st_r.wStrb[g]}};
    end
  endgenerate

  assign acceptHit = &((rxId ~^ st_r.filt[FLT_APAT_LSB +: 8]) |
                       st_r.filt[FLT_AMSK_LSB +: 8]);
  assign rejectHit = &((rxId ~^ st_r.filt[FLT_RPAT_LSB +: 8]) |
                       st_r.filt[FLT_RMSK_LSB +: 8]);
  assign notEmpty  = (st_r.wrIdx != st_r.rdIdx) || st_r.full;
  assign wrFire    = st_r.awHave && st_r.wHave && !st_r.bValid;

  assign s_axi_awready = !st_r.awHave;
  assign s_axi_wready  = !st_r.wHave;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign txValid       = st_r.txValid;
  assign txBuf         = st_r.txBuf;
  assign txId          = st_r.txId;
  assign txLen         = st_r.txLen;
  assign txData        = st_r.txData;
  assign fifoIrq = (notEmpty && st_r.ieNe) || (st_r.ovr && st_r.ieOvr);

  always_comb begin
    logic [3:0]         winBuf;
    logic [31:0]        wv;
    logic [NUM_BUF-1:0] newLock;
    logic [NUM_BUF-1:0] unlocked;
    logic [NUM_BUF-1:0] aborted;
    logic               found;
    logic [3:0]         best;
    logic               store;
    logic               lastIdx;
    winBuf   = '0;
    wv       = '0;
    newLock  = '0;
    unlocked = '0;
    aborted  = '0;
    found    = 1'b0;
    best     = '0;
    store    = 1'b0;
    lastIdx  = 1'b0;
    st_nxt   = st_r;
    // Window select zero shows the FIFO head while the FIFO depth is nonzero
    winBuf = (st_r.winSel == 4'h0 && st_r.depth != 5'h00) ?
             st_r.rdIdx : st_r.winSel;
    st_nxt.lockAck = st_r.lock;

    // Write channel
    if (s_axi_awvalid && !st_r.awHave) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wHave) begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    newLock = st_r.lock;
    if (wrFire) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = RESP_OKAY;
      wv = st_r.wData & wMask;
      case (st_r.awAddr)
        OFS_CTRL: begin
          if (st_r.wStrb[0]) begin
            st_nxt.depth = (wv[4:0] > 5'd16) ? 5'd16 : wv[4:0];
          end
          if (st_r.wStrb[1]) begin
            st_nxt.txFirst = wv[CTRL_TXF_LSB +: 4];
          end
          if (st_r.wStrb[2]) begin
            st_nxt.ieNe  = wv[CTRL_IENE_BIT];
            st_nxt.ieOvr = wv[CTRL_IEOVR_BIT];
          end
        end
        // The overrun flag clears only by writing one or by reset
        OFS_STATUS: st_nxt.ovr = st_r.ovr & ~wv[ST_OVR_BIT];
        OFS_FILTER: st_nxt.filt = (st_r.filt & ~wMask) | wv;
        OFS_LOCK: begin
          // One access may clear the flag and unlock together
          newLock = (st_r.lock & ~wMask[15:0]) | wv[15:0];
          st_nxt.lock = newLock;
          st_nxt.flag = st_r.flag & ~wv[31:16];
        end
        OFS_FLAG: begin
          st_nxt.flag  = st_r.flag & ~wv[15:0];
          st_nxt.abAck = st_r.abAck & ~wv[31:16];
        end
        OFS_ABORT:  st_nxt.abReq = st_r.abReq | (wv[15:0] & st_r.subm);
        OFS_WINSEL: st_nxt.winSel = wv[3:0];
        OFS_WINHDR: begin
          if (st_r.lock[st_r.winSel]) begin
            st_nxt.memId[winBuf]  = wv[ID_W-1:0];
            st_nxt.memLen[winBuf] = wv[HDR_LEN_LSB +: LEN_W];
          end
        end
        OFS_WINDAT: begin
          if (st_r.lock[st_r.winSel]) begin
            st_nxt.memData[winBuf] = (st_r.memData[winBuf] & ~wMask) | wv;
          end
        end
        default: st_nxt.bResp = RESP_SLVERR;
      endcase
    end
    unlocked = st_r.lock & ~newLock;
    // Submission on unlock of an empty transmit buffer
    st_nxt.subm = st_r.subm | (unlocked & txRange & ~st_nxt.flag);
    if (unlocked[0] && st_r.depth != 5'h00 && notEmpty) begin
      lastIdx = ({1'b0, st_r.rdIdx} == st_r.depth - 5'd1);
      st_nxt.rdIdx = lastIdx ? 4'h0 : st_r.rdIdx + 4'h1;
      st_nxt.full  = 1'b0;
      st_nxt.flag[st_r.rdIdx] = 1'b0;
    end

    // Read channel; indices are never moved here
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rValid) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: st_nxt.rData = {14'h0000, st_r.ieOvr, st_r.ieNe,
                                  4'h0, st_r.txFirst, 3'h0, st_r.depth};
        OFS_STATUS: st_nxt.rData = {29'h0000_0000, fifoIrq, st_r.ovr,
                                    notEmpty};
        OFS_FILTER: st_nxt.rData = st_r.filt;
        OFS_LOCK:   st_nxt.rData = {st_r.lockAck, st_r.lock};
        OFS_FLAG:   st_nxt.rData = {st_r.abAck, st_r.flag};
        OFS_ABORT:  st_nxt.rData = {st_r.subm, st_r.abReq};
        OFS_WINSEL: st_nxt.rData = {28'h000_0000, st_r.winSel};
        OFS_WINHDR: st_nxt.rData = {20'h0_0000, st_r.memLen[winBuf],
                                    st_r.memId[winBuf]};
        OFS_WINDAT: st_nxt.rData = st_r.memData[winBuf];
        default: begin
          st_nxt.rData = 32'h0000_0000;
          st_nxt.rResp = RESP_SLVERR;
        end
      endcase
    end

    // Receive into the FIFO
    if (rxDone && rxOk && !rxMailboxHit && st_r.depth != 5'h00 &&
        acceptHit && !rejectHit) begin
      if (st_r.full) begin
        st_nxt.ovr = 1'b1;
      end else begin
        store = 1'b1;
      end
    end
    if (store) begin
      st_nxt.memId[st_r.wrIdx]   = rxId;
      st_nxt.memLen[st_r.wrIdx]  = rxLen;
      st_nxt.memData[st_r.wrIdx] = rxData;
      st_nxt.flag[st_r.wrIdx]    = 1'b1;
      lastIdx = ({1'b0, st_r.wrIdx} == st_r.depth - 5'd1);
      st_nxt.wrIdx = lastIdx ? 4'h0 : st_r.wrIdx + 4'h1;
      st_nxt.full  = (lastIdx ? 4'h0 : st_r.wrIdx + 4'h1) ==
                     st_nxt.rdIdx;
    end

    // Lowest identifier wins, ties to lowest buffer
    for (int i = 0; i < NUM_BUF; i++) begin
      if (elig[i] && (!found || st_r.memId[i] < st_r.memId[best])) begin
        found = 1'b1;
        best  = 4'(i);
      end
    end
    st_nxt.txValid = found && !txDone;
    st_nxt.txBuf   = best;
    st_nxt.txId    = st_r.memId[best];
    st_nxt.txLen   = st_r.memLen[best];
    st_nxt.txData  = st_r.memData[best];
    if (txDone && st_r.txValid) begin
      st_nxt.sent[st_r.txBuf] = 1'b1;
      for (int i = 0; i < NUM_BUF; i++) begin
        if (st_r.armed[i] && st_r.memId[i] == st_r.txId &&
            4'(i) != st_r.txBuf) begin
          st_nxt.excl[i] = 1'b1;
        end
      end
    end

    // Communication cycle boundary
    if (syncPulse) begin
      aborted = st_r.subm & st_r.abReq;
      st_nxt.flag  = st_nxt.flag | st_r.sent | aborted;
      st_nxt.abAck = st_nxt.abAck | aborted;
      st_nxt.subm  = st_nxt.subm & ~(st_r.sent | aborted);
      st_nxt.abReq = st_nxt.abReq & ~aborted;
      st_nxt.armed = st_r.subm & ~(st_r.sent | aborted);
      st_nxt.sent  = '0;
      st_nxt.excl  = '0;
      st_nxt.txValid = 1'b0;
    end

    if (reset) begin
      st_nxt         = '0;
      st_nxt.depth   = RST_DEPTH;
      st_nxt.txFirst = RST_TXF;
      st_nxt.filt    = RST_FILTER;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  sequence s_lock0Release;
    wrFire && st_r.lock[0] && !st_nxt.lock[0];
  endsequence
  sequence s_acceptedRx;
    rxDone && rxOk && !rxMailboxHit && st_r.depth != 5'h00 &&
    acceptHit && !rejectHit;
  endsequence

  chk_read_advance: assert property (@(posedge clk) disable iff (reset)
    s_lock0Release ##0 (st_r.depth != 5'h00 && notEmpty && !syncPulse)
    |=> st_r.rdIdx != $past(st_r.rdIdx) || st_r.depth == 5'h01)
    else $error("read index did not advance on unlock");
  chk_write_wrap: assert property (@(posedge clk) disable iff (reset)
    s_acceptedRx ##0 (!st_r.full && {1'b0, st_r.wrIdx} == st_r.depth - 5'd1)
    |=> st_r.wrIdx == 4'h0)
    else $error("write index did not wrap");
  chk_ovr_set: assert property (@(posedge clk) disable iff (reset)
    s_acceptedRx ##0 st_r.full |=> st_r.ovr)
    else $error("overrun not flagged on full FIFO");
  chk_not_empty: assert property (@(posedge clk) disable iff (reset)
    (st_r.wrIdx != st_r.rdIdx) |-> s_axi_arvalid && !st_r.rValid &&
    s_axi_araddr == OFS_STATUS |=> st_r.rData[ST_NE_BIT])
    else $error("not-empty status missing");
  chk_reject_wins: assert property (@(posedge clk) disable iff (reset)
    rxDone && rejectHit && !st_r.full |=> st_r.wrIdx == $past(st_r.wrIdx))
    else $error("rejected identifier stored");
  chk_abort_ack: assert property (@(posedge clk) disable iff (reset)
    syncPulse && (st_r.subm[13] && st_r.abReq[13])
    |=> st_r.abAck[13] && st_r.flag[13] && !st_r.subm[13])
    else $error("abort not acknowledged at sync");
  chk_sent_flag: assert property (@(posedge clk) disable iff (reset)
    syncPulse && st_r.sent[12] && !st_r.abReq[12] && !st_r.abAck[12]
    |=> st_r.flag[12] && !st_r.abAck[12])
    else $error("sent buffer flag wrong at sync");
  chk_tx_armed: assert property (@(posedge clk) disable iff (reset)
    st_r.txValid |-> st_r.armed[st_r.txBuf] && txRange[st_r.txBuf])
    else $error("unarmed buffer offered");
  chk_irq_gate: assert property (@(posedge clk) disable iff (reset)
    fifoIrq |-> (notEmpty && st_r.ieNe) || (st_r.ovr && st_r.ieOvr))
    else $error("interrupt without enabled cause");
  chk_full_hold: assert property (@(posedge clk) disable iff (reset)
    st_r.full |-> st_r.wrIdx == st_r.rdIdx)
    else $error("full flag with unequal indices");

endmodule // mbf_msg_buffer
